// >>> hw/pmc_ctrl.sv
// power-managed clock mode controller
`timescale 1ns/100ps
// Summary of operation
// - internal run: cpu and peripherals on internal oscillator, primary stopped
// - select field 11 chooses internal oscillator run
// - on switch to internal, primary stops and start status clears
// - leaving internal for primary waits on primary ready before switching
// - switch to primary complete sets start status, primary drives clock
// - hardware switch leaves idle enable and select field untouched
// - internal oscillator kept running while watchdog or monitor enabled
// - primary idle keeps primary clock running
// - primary idle halts cpu, peripherals on primary, start status stays
// - wake in primary idle restarts cpu after start delay
// - wake from primary idle keeps status, idle enable and select
// - secondary idle halts cpu, peripherals on timer1 oscillator
// - switch to timer1 stops primary, clears start status, sets secondary running
// - wake in secondary idle resumes cpu on timer1 after delay, settings kept
// - power-save ignored for secondary idle when timer1 enable clear
// - on secondary idle entry, peripheral clocks withheld until timer1 oscillator runs

// mode flow
//   run: source follows the select field, timer1 only with timer1 enable set (else primary); internal and timer1 switch at once
//   primary wait: the current source (internal or timer1) keeps the clock until the synchronised ready arrives
//   timer1 wait: sleep taken but peripherals gated until timer1 runs
//   idle: cpu gated, peripherals stay on the current source
//   start: wake seen, delay counter runs down before the cpu restarts
// hazards
//   ready and wake pins are synchronised, so they lag the pins by 3 to 4 cycles
//   software must let a ready pin settle before it asks for a switch
//   the sleep bit acts on the select and idle enable held before the write
//   select 10 outside idle behaves as primary run
//   sleep with idle enable clear is ignored, full sleep is not modelled
//   gate outputs are registered, one cycle behind state and source
//   source output is the source register src_q itself, no extra delay
// register map
//   control: select [1:0], idle enable [2], timer1 enable [3], sleep [8]
//   status: start status [0], secondary running [1], state [6:2], source [9:7]
//   delay: start delay cycles [15:0]
//   unmapped reads return zero, unmapped writes are dropped
module pmc_ctrl #(
	parameter int DLY_W = 16    // width of start delay counter
) (
	input  wire logic             sys_clk_i,     // 100 MHz clock
	input  wire logic             sys_rst_i,     // async reset, active high
	input  wire logic             clk_en_i,      // freezes all state when low
	input  wire logic [3:0]       reg_addr_i,    // register address
	input  wire logic [31:0]      reg_wdata_i,   // write data
	input  wire logic             reg_wr_i,      // write strobe
	input  wire logic             reg_rd_i,      // read strobe
	output logic      [31:0]      reg_rdata_o,   // read data, next cycle
	input  wire logic             wake_i,        // wake event pin
	input  wire logic             pri_rdy_i,     // primary oscillator ready pin
	input  wire logic             t1_rdy_i,      // timer1 oscillator running pin
	input  wire logic             wdt_en_i,      // watchdog enabled
	input  wire logic             fscm_en_i,     // fail-safe monitor enabled
	output pmc_pkg::pmc_gate_t    gate_o,        // clock enables
	output pmc_pkg::pmc_src_t     src_o          // selected device clock source
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change counted when 2 and 3 agree
	logic [2:0] sync_q [3];
	logic [2:0] sync_d [3];
	logic [2:0] pin_in;
	logic [2:0] flt_q, flt_d;
	assign pin_in = {t1_rdy_i, pri_rdy_i, wake_i};

	// next values of the synchroniser chains and filtered levels
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// shift the pin in; accept a level once stages two and three agree
			sync_d[i] = {sync_q[i][1:0], pin_in[i]};
			flt_d[i]  = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2] : flt_q[i];
		end
	end

	// synchroniser registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 3; i++) begin
				sync_q[i] <= 3'h0;
			end
			flt_q <= 3'h0;
		end else if (clk_en_i) begin
			sync_q <= sync_d;
			flt_q  <= flt_d;
		end
	end

	// synchronised levels and the wake edge
	logic wake_s, pri_rdy_s, t1_rdy_s;
	logic wake_prev_q, wake_prev_d;
	logic wake_ev;
	assign wake_s    = flt_q[0];
	assign pri_rdy_s = flt_q[1];
	assign t1_rdy_s  = flt_q[2];
	assign wake_ev   = wake_s & ~wake_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// mode state machine
	// one-hot mode states
	typedef enum logic [4:0] {
		ST_RUN      = 5'b00001,
		ST_PRI_WAIT = 5'b00010,
		ST_IDLE     = 5'b00100,
		ST_T1_WAIT  = 5'b01000,
		ST_START    = 5'b10000
	} pmc_state_t;

	pmc_state_t        state_q, state_d;
	pmc_pkg::pmc_src_t src_q, src_d;
	// software settings
	logic [1:0]        sel_q, sel_d;
	logic              idle_en_q, idle_en_d;
	logic              t1_en_q, t1_en_d;
	// hardware status
	logic              oscillator_start_status_q, oscillator_start_status_d;
	logic              secondary_clock_running_q, secondary_clock_running_d;
	// start delay and its counter
	logic [DLY_W-1:0]  dly_q, dly_d;
	logic [DLY_W-1:0]  cnt_q, cnt_d;
	// decoded requests
	logic              sleep_req;
	logic              secondary_idle_mode;

	// power-save request: sleep bit written to control
	assign sleep_req = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_CTRL)
	                   && reg_wdata_i[pmc_pkg::CTRL_SLEEP_BIT];

	// next mode, source, status and register values
	always_comb begin
		state_d     = state_q;
		src_d       = src_q;
		sel_d       = sel_q;
		idle_en_d   = idle_en_q;
		t1_en_d     = t1_en_q;
		oscillator_start_status_d      = oscillator_start_status_q;
		secondary_clock_running_d     = secondary_clock_running_q;
		dly_d       = dly_q;
		cnt_d       = cnt_q;
		wake_prev_d = wake_s;

		// software writes; hardware switches never touch these
		if (reg_wr_i && reg_addr_i == pmc_pkg::OFS_CTRL) begin
			sel_d     = reg_wdata_i[pmc_pkg::CTRL_SEL_LSB +: 2];
			idle_en_d = reg_wdata_i[pmc_pkg::CTRL_IDLE_BIT];
			t1_en_d   = reg_wdata_i[pmc_pkg::CTRL_T1EN_BIT];
		end else if (reg_wr_i && reg_addr_i == pmc_pkg::OFS_DELAY) begin
			dly_d = reg_wdata_i[DLY_W-1:0];
		end

		case (state_q)
			ST_RUN: begin
				// source follows the select field
				if (sel_q == pmc_pkg::SEL_INTERNAL) begin
					src_d  = pmc_pkg::SRC_INT;
					oscillator_start_status_d = 1'b0;
				end else if (sel_q == pmc_pkg::SEL_SECONDARY && t1_en_q) begin
					src_d   = pmc_pkg::SRC_T1;
					oscillator_start_status_d  = 1'b0;
					secondary_clock_running_d = 1'b1;
				end else if (src_q != pmc_pkg::SRC_PRI) begin
					state_d = ST_PRI_WAIT;
				end
				// secondary running drops once timer1 is neither the source nor selected
				if (src_q != pmc_pkg::SRC_T1 && sel_q != pmc_pkg::SEL_SECONDARY) begin
					secondary_clock_running_d = 1'b0;
				end
				// power-save, judged on settings held before this write
				if (sleep_req && idle_en_q) begin
					if (sel_q == pmc_pkg::SEL_SECONDARY && !t1_en_q) begin
						state_d = ST_RUN;
					end else if (sel_q == pmc_pkg::SEL_SECONDARY && !t1_rdy_s) begin
						state_d = ST_T1_WAIT;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_PRI_WAIT: begin
				// the current source keeps the clock until primary is ready
				if (pri_rdy_s) begin
					src_d   = pmc_pkg::SRC_PRI;
					oscillator_start_status_d  = 1'b1;
					secondary_clock_running_d = 1'b0;
					state_d = ST_RUN;
				end
			end
			ST_T1_WAIT: begin
				// peripherals held off until timer1 oscillates
				if (t1_rdy_s) begin
					src_d   = pmc_pkg::SRC_T1;
					oscillator_start_status_d  = 1'b0;
					secondary_clock_running_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				// cpu halted, wait for a wake edge
				if (wake_ev) begin
					cnt_d   = dly_q;
					state_d = ST_START;
				end
			end
			ST_START: begin
				// count down the start delay
				if (cnt_q == '0) begin
					state_d = ST_RUN;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: state_d = ST_RUN;
		endcase
	end

	// mode registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// power-up waits on primary with the internal clock running
			state_q     <= ST_PRI_WAIT;
			src_q       <= pmc_pkg::SRC_INT;
			sel_q       <= pmc_pkg::RST_SEL;
			idle_en_q   <= 1'b0;
			t1_en_q     <= 1'b0;
			oscillator_start_status_q      <= 1'b0;
			secondary_clock_running_q     <= 1'b0;
			dly_q       <= DLY_W'(pmc_pkg::RST_DELAY);
			cnt_q       <= '0;
			wake_prev_q <= 1'b0;
		end else if (clk_en_i) begin
			state_q     <= state_d;
			src_q       <= src_d;
			sel_q       <= sel_d;
			idle_en_q   <= idle_en_d;
			t1_en_q     <= t1_en_d;
			oscillator_start_status_q      <= oscillator_start_status_d;
			secondary_clock_running_q     <= secondary_clock_running_d;
			dly_q       <= dly_d;
			cnt_q       <= cnt_d;
			wake_prev_q <= wake_prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock gating outputs and read data
	pmc_pkg::pmc_gate_t gate_d, gate_q;
	logic [31:0]        rdata_d, rdata_q;
	assign secondary_idle_mode = (src_q == pmc_pkg::SRC_T1);

	// next gate enables
	always_comb begin
		gate_d.cpu_en     = (state_q == ST_RUN) || (state_q == ST_PRI_WAIT);
		gate_d.per_en     = (state_q != ST_T1_WAIT);
		gate_d.pri_osc_en = (src_q == pmc_pkg::SRC_PRI)
		                    || (state_q == ST_PRI_WAIT);
		gate_d.int_osc_en = (src_q == pmc_pkg::SRC_INT) || (state_q == ST_PRI_WAIT)
		                    || wdt_en_i || fscm_en_i;
		gate_d.t1_osc_en  = t1_en_q || secondary_idle_mode;
	end

	// next read data
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd_i) begin
			if (reg_addr_i == pmc_pkg::OFS_CTRL) begin
				// control register
				rdata_d[pmc_pkg::CTRL_SEL_LSB +: 2] = sel_q;
				rdata_d[pmc_pkg::CTRL_IDLE_BIT]     = idle_en_q;
				rdata_d[pmc_pkg::CTRL_T1EN_BIT]     = t1_en_q;
			end else if (reg_addr_i == pmc_pkg::OFS_STATUS) begin
				// status register
				rdata_d[0]   = oscillator_start_status_q;
				rdata_d[1]   = secondary_clock_running_q;
				rdata_d[6:2] = state_q;
				rdata_d[9:7] = src_q;
			end else if (reg_addr_i == pmc_pkg::OFS_DELAY) begin
				// delay register
				rdata_d[DLY_W-1:0] = dly_q;
			end
		end
	end

	// output registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// all clocks gated during reset
			gate_q  <= '0;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en_i) begin
			gate_q  <= gate_d;
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from registers
	assign gate_o      = gate_q;
	assign src_o       = src_q;
	assign reg_rdata_o = rdata_q;

endmodule : pmc_ctrl

// >>> hw/pmc_pkg.sv
// package for the power-managed clock mode controller
package pmc_pkg;

	// clock-select field encodings
	localparam logic [1:0] SEL_PRIMARY   = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	localparam logic [1:0] SEL_PRIMARY_IDLE_MODE  = 2'h2;
	localparam logic [1:0] SEL_INTERNAL  = 2'h3;

	// register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_DELAY  = 4'h8;

	// control field positions
	localparam int CTRL_SEL_LSB   = 0;
	localparam int CTRL_IDLE_BIT  = 2;
	localparam int CTRL_T1EN_BIT  = 3;
	localparam int CTRL_SLEEP_BIT = 8;

	// reset values
	localparam logic [1:0]  RST_SEL   = 2'h0;
	localparam logic [15:0] RST_DELAY = 16'h000A;

	// clock source of the device clock
	typedef enum logic [2:0] {
		SRC_PRI = 3'b001,
		SRC_INT = 3'b010,
		SRC_T1  = 3'b100
	} pmc_src_t;

	// clock gating outputs
	typedef struct packed {
		logic cpu_en;
		logic per_en;
		logic pri_osc_en;
		logic int_osc_en;
		logic t1_osc_en;
	} pmc_gate_t;

endpackage : pmc_pkg

// >>> verif/pmc_ctrl_assertions.sv
// checker for the clock mode controller
`timescale 1ns/100ps
module pmc_ctrl_assertions (
	input wire logic          sys_clk_i,   // clock
	input wire logic          sys_rst_i,   // reset
	input wire logic          clk_en_i,    // run enable
	input wire logic [3:0]    reg_addr_i,  // address
	input wire logic [31:0]   reg_wdata_i, // write data
	input wire logic          reg_wr_i,    // write strobe
	input wire logic          reg_rd_i,    // read strobe
	input wire logic [31:0]   reg_rdata_o, // read data
	input wire logic          pri_rdy_i,   // primary ready
	input wire logic          t1_rdy_i,    // timer1 running
	input wire logic          wdt_en_i,    // watchdog on
	input wire logic          fscm_en_i,   // monitor on
	input pmc_pkg::pmc_gate_t gate_o,      // clock enables
	input pmc_pkg::pmc_src_t  src_o        // clock source
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////
	// bus and mode relations
	AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data not zero");
	AST_UNMAPPED: assert property (reg_rd_i && clk_en_i && reg_addr_i == 4'hC
		|=> reg_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
	AST_SEL_INT: assert property (reg_wr_i && clk_en_i && reg_addr_i == pmc_pkg::OFS_CTRL
		&& reg_wdata_i[1:0] == pmc_pkg::SEL_INTERNAL
		|-> ##[1:3] src_o == pmc_pkg::SRC_INT) else $error("no internal switch");
	AST_PRI_RDY: assert property ($changed(src_o) && src_o == pmc_pkg::SRC_PRI
		|-> $past(pri_rdy_i, 3)) else $error("primary taken before ready");
	AST_WDT: assert property ((wdt_en_i || fscm_en_i) [*3] |-> gate_o.int_osc_en)
		else $error("internal osc stopped");
	AST_T1_PRI_OFF: assert property (src_o == pmc_pkg::SRC_T1 [*3] |-> !gate_o.pri_osc_en)
		else $error("primary runs on timer1");
	AST_T1_PER: assert property ($rose(gate_o.per_en) && !gate_o.cpu_en
		|-> $past(t1_rdy_i, 2)) else $error("peripherals before timer1");
	AST_FREEZE: assert property (!clk_en_i [*2] |-> $stable(src_o))
		else $error("source moved while frozen");
	C_PIDLE: cover property (src_o == pmc_pkg::SRC_PRI && !gate_o.cpu_en);
	C_SIDLE: cover property (src_o == pmc_pkg::SRC_T1 && !gate_o.cpu_en);
	C_WAKE: cover property ($rose(gate_o.cpu_en));
endmodule : pmc_ctrl_assertions

// >>> verif/tb.sv
// testbench for the clock mode controller
`timescale 1ns/100ps
module tb;
	logic               sys_clk_i   = 1'b0;
	logic               sys_rst_i   = 1'b1;
	logic               clk_en_i    = 1'b1;
	logic [3:0]         reg_addr_i  = 4'h0;
	logic [31:0]        reg_wdata_i = 32'h0000_0000;
	logic               reg_wr_i    = 1'b0;
	logic               reg_rd_i    = 1'b0;
	logic               wake_i      = 1'b0;
	logic               pri_rdy_i   = 1'b1;
	logic               t1_rdy_i    = 1'b1;
	logic               wdt_en_i    = 1'b0;
	logic               fscm_en_i   = 1'b0;
	logic [31:0]        reg_rdata_o;
	pmc_pkg::pmc_gate_t gate_o;
	pmc_pkg::pmc_src_t  src_o;
	logic [7:0]         obs;
	int                 error_cnt = 0;
	int                 cmp_count = 0;
	int                 n;
	// src in [7:5], cpu per pri int t1 in [4:0]
	assign obs = {src_o, gate_o};
	always #5 sys_clk_i = ~sys_clk_i;
	pmc_ctrl i_pmc_ctrl (.sys_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .wake_i, .pri_rdy_i, .t1_rdy_i,
		.wdt_en_i, .fscm_en_i, .gate_o, .src_o);
	////////////////////////////////////////////////////////////////
	// shared helpers
	task chk(input logic c);
		cmp_count++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t mismatch", $time);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		@(posedge sys_clk_i) reg_wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge sys_clk_i) reg_rd_i <= 1'b0;
		#1 chk((reg_rdata_o & m) === e);
	endtask : rd
	// waits until the masked outputs match, bounded
	task wt(input logic [7:0] m, input logic [7:0] v, output int k);
		#1;
		for (k = 1; k < 60 && (obs & m) !== v; k++) begin
			@(posedge sys_clk_i) #1;
		end
		chk((obs & m) === v);
	endtask : wt
	task wake(output int k);
		@(posedge sys_clk_i) wake_i <= 1'b1;
		wt(8'h10, 8'h10, k);
		@(posedge sys_clk_i) wake_i <= 1'b0;
	endtask : wake
	////////////////////////////////////////////////////////////////
	// scenarios
	task s_reset;
		wt(8'hE0, 8'h20, n);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		rd(pmc_pkg::OFS_DELAY, 32'h0000_FFFF, {16'h0000, pmc_pkg::RST_DELAY});
		rd(pmc_pkg::OFS_CTRL, 32'h0000_0007, {30'h0, pmc_pkg::RST_SEL});
		wr(4'hC, 32'hFFFF_FFFF);
		rd(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask : s_reset
	task s_int;
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0003);
		wt(8'hE0, 8'h40, n);
		@(posedge sys_clk_i) #1 chk((obs & 8'h1C) === 8'h18);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
	endtask : s_int
	task s_back;
		@(posedge sys_clk_i) {pri_rdy_i, wdt_en_i} <= 2'b01;
		repeat (6) @(posedge sys_clk_i);
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0000);
		@(posedge sys_clk_i) clk_en_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
		#1 chk((obs & 8'hE4) === 8'h44);
		@(posedge sys_clk_i) pri_rdy_i <= 1'b1;
		wt(8'hE0, 8'h20, n);
		chk(obs[1] === 1'b1);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		rd(pmc_pkg::OFS_CTRL, 32'h0000_0007, 32'h0000_0000);
	endtask : s_back
	task s_pidle;
		wr(pmc_pkg::OFS_DELAY, 32'h0000_0014);
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0006);
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0106);
		wt(8'h10, 8'h00, n);
		chk((obs & 8'hFC) === 8'h2C);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
		wake(n);
		chk(n >= 21 && n <= 32);
		chk((obs & 8'hE0) === 8'h20);
		rd(pmc_pkg::OFS_CTRL, 32'h0000_0007, 32'h0000_0006);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
	endtask : s_pidle
	task s_t1_off;
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0005);
		wr(pmc_pkg::OFS_CTRL, 32'h0000_0105);
		repeat (10) @(posedge sys_clk_i);
		#1 chk(obs[4] === 1'b1);
	endtask : s_t1_off
	task s_sidle;
		@(posedge sys_clk_i) t1_rdy_i <= 1'b0;
		wr(pmc_pkg::OFS_CTRL, 32'h0000_000D);
		wt(8'hE0, 8'h80, n);
		@(posedge sys_clk_i) #1 chk((obs & 8'h05) === 8'h01);
		rd(pmc_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
		wr(pmc_pkg::OFS_CTRL, 32'h0000_010D);
		wt(8'h18, 8'h00, n);
		@(posedge sys_clk_i) t1_rdy_i <= 1'b1;
		wt(8'h18, 8'h08, n);
		wake(n);
		chk((obs & 8'hF1) === 8'h91);
		rd(pmc_pkg::OFS_CTRL, 32'h0000_000F, 32'h0000_000D);
		@(posedge sys_clk_i) {wdt_en_i, fscm_en_i} <= 2'b01;
		repeat (2) @(posedge sys_clk_i);
		#1 chk(obs[1] === 1'b1);
		@(posedge sys_clk_i) fscm_en_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1 chk(obs[1] === 1'b0);
	endtask : s_sidle
	////////////////////////////////////////////////////////////////
	// verdict and run control
	task summarize;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial begin
		#200us error_cnt++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		s_reset();
		s_int();
		s_back();
		s_pidle();
		s_t1_off();
		s_sidle();
		summarize();
	end
endmodule : tb
bind pmc_ctrl pmc_ctrl_assertions i_pmc_ctrl_assertions (.sys_clk_i, .sys_rst_i, .clk_en_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pri_rdy_i, .t1_rdy_i,
	.wdt_en_i, .fscm_en_i, .gate_o, .src_o);
